/* File: verilog/scsp_top.sv */
/*
  Switch configured serial port: baud divider, transmitter, flow control, clock-string sender.
  Assumes switch, jumper and line inputs are asynchronous; received bytes go to a command
  interpreter that raises read_clock_i; rtc_chars_i is the 11-character clock string.
*/
//
// Overview of operation
// - Jumper selects voltage-level or current-loop lines; one shared transceiver.
// - Three switches pick 300 to 9600 baud; host must match.
// - Format switches give none, even or odd parity; parity generated and checked.
// - Every frame has exactly one stop bit.
// - Data field is eight or seven bits; seven only without parity.
// - Flow switch off: RTS active while receive room; on: XON/XOFF sent.
// - Loop ready output follows the same readiness in current-loop mode.
// - DTR active while the printer is powered and operating.
// - Switch enables transmission started by holding the print key.
// - Receive on RXD or loop input; transmit on TXD or loop output.
// - Read-clock command sends the clock as eleven ASCII characters.
`timescale 1ns/10ps
`include "scsp_params.svh"
module scsp_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Switches and jumper
  input wire logic [2:0] baud_sw_i,
  input wire logic [2:0] fmt_sw_i,
  input wire logic xon_xoff_sw_i,
  input wire logic key_tx_sw_i,
  input wire logic line_standard_jumper_i,
  // Lines
  input wire logic rxd_i,
  input wire logic loop_receive_i,
  output logic txd_o,
  output logic loop_transmit_positive_o,
  output logic rts_o,
  output logic loop_ready_o,
  output logic dtr_o,
  // Printer side
  input wire logic operating_i,
  input wire logic print_key_i,
  input wire logic rx_room_i,
  input wire logic read_clock_i,
  input wire logic [87:0] rtc_chars_i,
  input wire logic [7:0] key_data_i,
  output scsp_pkg::scsp_byte_t rx_o,
  output logic parity_err_o,
  output logic key_taken_o,
  output logic clock_busy_o
);
  function automatic logic [`SCSP_DIV_W-1:0] div_for(input logic [2:0] code);
    logic [31:0] bd;
    bd = 32'd1200;
    unique case (code)
      `SCSP_BAUD_300: bd = 32'd300;
      `SCSP_BAUD_600: bd = 32'd600;
      `SCSP_BAUD_2400: bd = 32'd2400;
      `SCSP_BAUD_4800: bd = 32'd4800;
      `SCSP_BAUD_9600: bd = 32'd9600;
      default: bd = 32'd1200;
    endcase
    div_for = `SCSP_DIV_W'(`SCSP_CLK_HZ / (bd * `SCSP_OVS) - 1);
  endfunction

  // Synchronisers
  logic [4:0] s1_ff;
  logic [4:0] s2_ff;
  logic [7:0] sw1_ff;
  logic [7:0] sw2_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= 5'h18;
      s2_ff <= 5'h18;
      sw1_ff <= 8'h00;
      sw2_ff <= 8'h00;
    end else begin
      s1_ff <= {rxd_i, loop_receive_i, line_standard_jumper_i, print_key_i, operating_i};
      s2_ff <= s1_ff;
      sw1_ff <= {baud_sw_i, fmt_sw_i, xon_xoff_sw_i, key_tx_sw_i};
      sw2_ff <= sw1_ff;
    end
  end
  wire s_rxd = s2_ff[4];
  wire s_lrx = s2_ff[3];
  wire s_loop = s2_ff[2];
  wire s_key = s2_ff[1];
  wire s_oper = s2_ff[0];
  wire [2:0] s_baud = sw2_ff[7:5];
  wire [2:0] s_fmt = sw2_ff[4:2];
  wire s_xon = sw2_ff[1];
  wire s_keyen = sw2_ff[0];

  scsp_pkg::scsp_fmt_t fmt;
  assign fmt.parity_en = (s_fmt == `SCSP_FMT_E81) || (s_fmt == `SCSP_FMT_O81);
  assign fmt.parity_odd = (s_fmt == `SCSP_FMT_O81);
  assign fmt.seven_bit = (s_fmt == `SCSP_FMT_N71);

  // Baud tick divider
  logic [`SCSP_DIV_W-1:0] div_ff;
  logic tick_ff;
  wire [`SCSP_DIV_W-1:0] div_max = div_for(s_baud);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_ff <= '0;
      tick_ff <= 1'h0;
    end else begin
      tick_ff <= (div_ff >= div_max);
      div_ff <= (div_ff >= div_max) ? '0 : div_ff + `SCSP_DIV_W'(1);
    end
  end

  wire rx_line = s_loop ? s_lrx : s_rxd;
  scsp_rx u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_ff),
    .fmt_i(fmt),
    .rxd_i(rx_line),
    .rx_o(rx_o),
    .parity_err_o(parity_err_o)
  );

  // Transmitter and source selection
  typedef enum logic [1:0] {T_IDLE, T_SHIFT} scsp_tx_state_t;
  scsp_tx_state_t tst_ff;
  logic [10:0] tsh_ff;
  logic [3:0] tcnt_ff;
  logic [3:0] ttk_ff;
  logic [3:0] cidx_ff;
  logic room_ff;
  logic key_prev_ff;
  logic key_pend_ff;
  logic line_ff;
  wire ready = rx_room_i;
  wire need_x = s_xon && (ready != room_ff);
  wire [7:0] chr = rtc_chars_i[8'd87 - {cidx_ff, 3'h0} -: 8];
  wire [7:0] tx_byte = need_x ? (ready ? `SCSP_XON : `SCSP_XOFF) :
                       clock_busy_o ? chr : key_data_i;
  wire key_go = key_pend_ff && s_keyen;
  wire tx_go = (tst_ff == T_IDLE) && (need_x || clock_busy_o || key_go);
  wire tpar = (^tx_byte[6:0]) ^ (!fmt.seven_bit && tx_byte[7]) ^ fmt.parity_odd;
  // Frame LSB first: start, data, optional parity, one stop
  wire [10:0] frame = fmt.parity_en ? {1'h1, tpar, tx_byte, 1'h0} :
                      fmt.seven_bit ? {2'h3, 1'h1, tx_byte[6:0], 1'h0} : {2'h3, tx_byte, 1'h0};
  wire [3:0] tbits = 4'h9 + {3'h0, fmt.parity_en} - {3'h0, fmt.seven_bit};
  wire bit_end = tick_ff && (ttk_ff == `SCSP_LAST_TICK);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tst_ff <= T_IDLE;
      tsh_ff <= 11'h7FF;
      tcnt_ff <= 4'h0;
      ttk_ff <= 4'h0;
      cidx_ff <= 4'h0;
      room_ff <= 1'h1;
      clock_busy_o <= 1'h0;
      key_prev_ff <= 1'h0;
      key_pend_ff <= 1'h0;
      key_taken_o <= 1'h0;
      line_ff <= 1'h1;
    end else begin
      key_taken_o <= 1'h0;
      key_prev_ff <= s_key;
      if (!s_keyen) key_pend_ff <= 1'h0;
      else if (s_key && !key_prev_ff) key_pend_ff <= 1'h1;
      if (read_clock_i) clock_busy_o <= 1'h1;
      if (tick_ff) ttk_ff <= ttk_ff + 4'h1;
      unique case (tst_ff)
        T_IDLE: if (tx_go) begin
          tst_ff <= T_SHIFT;
          tsh_ff <= frame;
          tcnt_ff <= 4'h0;
          ttk_ff <= 4'h0;
          if (need_x) room_ff <= ready;
          else if (clock_busy_o) begin
            cidx_ff <= cidx_ff + 4'h1;
            if (cidx_ff + 4'h1 == `SCSP_CLK_CHARS) begin
              cidx_ff <= 4'h0;
              clock_busy_o <= read_clock_i;
            end
          end else begin
            key_pend_ff <= s_key && s_keyen;
            key_taken_o <= 1'h1;
          end
        end
        T_SHIFT: if (bit_end) begin
          tsh_ff <= {1'h1, tsh_ff[10:1]};
          tcnt_ff <= tcnt_ff + 4'h1;
          if (tcnt_ff == tbits) tst_ff <= T_IDLE;
        end
        default: tst_ff <= T_IDLE;
      endcase
      line_ff <= (tst_ff == T_SHIFT) ? tsh_ff[0] : 1'h1;
    end
  end
  // Line outputs, all registered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      txd_o <= 1'h1;
      loop_transmit_positive_o <= 1'h1;
      rts_o <= 1'h0;
      loop_ready_o <= 1'h0;
      dtr_o <= 1'h0;
    end else begin
      txd_o <= s_loop ? 1'h1 : line_ff;
      loop_transmit_positive_o <= s_loop ? line_ff : 1'h1;
      rts_o <= !s_loop && (s_xon || ready);
      loop_ready_o <= s_loop && (s_xon || ready);
      dtr_o <= s_oper;
    end
  end
endmodule

/* File: verilog/scsp_params.svh */
/*
  Timing, encoding and switch-decode constants for the switch configured serial port.
  Assumes a 125 MHz system clock.
*/
`ifndef SCSP_PARAMS_SVH
`define SCSP_PARAMS_SVH

`define SCSP_CLK_HZ 125000000
`define SCSP_OVS 16
`define SCSP_DIV_W 16
// Baud switch codes {dip3,dip2,dip1}, 1 = ON
`define SCSP_BAUD_300 3'h3
`define SCSP_BAUD_600 3'h2
`define SCSP_BAUD_1200 3'h0
`define SCSP_BAUD_2400 3'h1
`define SCSP_BAUD_4800 3'h7
`define SCSP_BAUD_9600 3'h6
// Format switch codes {dip6,dip7,dip8}
`define SCSP_FMT_N81 3'h0
`define SCSP_FMT_E81 3'h1
`define SCSP_FMT_O81 3'h5
`define SCSP_FMT_N71 3'h4
// Flow characters
`define SCSP_XON 8'h11
`define SCSP_XOFF 8'h13
// Clock string length and bit tick positions
`define SCSP_CLK_CHARS 4'hB
`define SCSP_MID_TICK 4'h7
`define SCSP_LAST_TICK 4'hF
`endif

/* File: verilog/scsp_pkg.sv */
/*
  Types for the switch configured serial port.
  Assumes scsp_params.svh constants.
*/
package scsp_pkg;
  typedef struct packed {
    logic parity_en;
    logic parity_odd;
    logic seven_bit;
  } scsp_fmt_t;
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } scsp_byte_t;
endpackage

/* File: verilog/scsp_rx.sv */
/*
  Serial receiver with 16x oversampling.
  Assumes rxd_i is already synchronised and tick_i is the 16x enable.
*/
`timescale 1ns/10ps
`include "scsp_params.svh"
module scsp_rx (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic tick_i,
  input wire scsp_pkg::scsp_fmt_t fmt_i,
  input wire logic rxd_i,
  // Result
  output scsp_pkg::scsp_byte_t rx_o,
  output logic parity_err_o
);
  typedef enum logic [1:0] {IDLE, START, BITS, STOP} scsp_rx_state_t;
  scsp_rx_state_t st_ff;
  logic [3:0] tk_ff;
  logic [3:0] bit_ff;
  logic [8:0] sh_ff;
  logic prev_ff;
  wire [3:0] nbits = 4'h7 + {3'h0, ~fmt_i.seven_bit} + {3'h0, fmt_i.parity_en};
  wire mid = tick_i && (tk_ff == `SCSP_MID_TICK);
  wire [7:0] dat = fmt_i.parity_en ? sh_ff[7:0] : (fmt_i.seven_bit ? {1'h0, sh_ff[8:2]} : sh_ff[8:1]);
  wire par_bad = fmt_i.parity_en && ((^sh_ff) ^ fmt_i.parity_odd);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= IDLE;
      tk_ff <= 4'h0;
      bit_ff <= 4'h0;
      sh_ff <= 9'h000;
      prev_ff <= 1'h1;
      rx_o <= '0;
      parity_err_o <= 1'h0;
    end else begin
      rx_o.valid <= 1'h0;
      parity_err_o <= 1'h0;
      prev_ff <= rxd_i;
      if (tick_i) tk_ff <= tk_ff + 4'h1;
      unique case (st_ff)
        IDLE: if (prev_ff && !rxd_i) begin
          st_ff <= START;
          tk_ff <= 4'h0;
        end
        START: if (mid) st_ff <= rxd_i ? IDLE : BITS;
        BITS: if (mid) begin
          sh_ff <= {rxd_i, sh_ff[8:1]};
          bit_ff <= bit_ff + 4'h1;
          if (bit_ff + 4'h1 == nbits) st_ff <= STOP;
        end
        STOP: if (mid) begin
          st_ff <= IDLE;
          bit_ff <= 4'h0;
          if (rxd_i) begin
            rx_o.data <= dat;
            rx_o.valid <= !par_bad;
            parity_err_o <= par_bad;
          end
        end
      endcase
    end
  end
endmodule

/* File: test/scsp_monitor.sv */
/* Checker for the serial port top module ports.
   Assumes it is bound to scsp_top. */
`timescale 1ns/10ps
module scsp_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Switches and jumper
  input wire logic xon_xoff_sw_i,
  input wire logic key_tx_sw_i,
  input wire logic line_standard_jumper_i,
  // Lines
  input wire logic txd_o,
  input wire logic loop_transmit_positive_o,
  input wire logic rts_o,
  input wire logic loop_ready_o,
  input wire logic dtr_o,
  // Printer side
  input wire logic operating_i,
  input wire logic rx_room_i,
  input wire scsp_pkg::scsp_byte_t rx_o,
  input wire logic parity_err_o,
  input wire logic key_taken_o,
  input wire logic clock_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rts_room: assert property (($stable(rx_room_i) && !line_standard_jumper_i && !xon_xoff_sw_i)[*5]
    |-> rts_o == rx_room_i) else $error("rts does not follow room");
  a_loop_ready: assert property (($stable(rx_room_i) && line_standard_jumper_i && !xon_xoff_sw_i)[*5]
    |-> loop_ready_o == rx_room_i) else $error("loop ready does not follow room");
  a_dtr_follow: assert property ($stable(operating_i)[*5] |-> dtr_o == operating_i)
    else $error("dtr does not follow operating");
  a_idle_other: assert property ($stable(line_standard_jumper_i)[*5]
    |-> (line_standard_jumper_i ? txd_o : loop_transmit_positive_o)) else $error("unused line not idle");
  a_rx_pulse: assert property (rx_o.valid |=> !rx_o.valid)
    else $error("valid longer than one cycle");
  a_perr_alone: assert property (parity_err_o |-> !rx_o.valid ##1 !parity_err_o)
    else $error("parity error with valid or too long");
  a_key_off: assert property ((!key_tx_sw_i)[*5] |-> !key_taken_o)
    else $error("key byte while disabled");
  a_clock_start: assert property ($rose(clock_busy_o) |->
    ##[1:1000] !(line_standard_jumper_i ? loop_transmit_positive_o : txd_o)) else $error("no start bit");
endmodule
bind scsp_top scsp_monitor scsp_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .xon_xoff_sw_i(xon_xoff_sw_i),
  .key_tx_sw_i(key_tx_sw_i), .line_standard_jumper_i(line_standard_jumper_i), .txd_o(txd_o),
  .loop_transmit_positive_o(loop_transmit_positive_o), .rts_o(rts_o), .loop_ready_o(loop_ready_o),
  .dtr_o(dtr_o), .operating_i(operating_i), .rx_room_i(rx_room_i), .rx_o(rx_o),
  .parity_err_o(parity_err_o), .key_taken_o(key_taken_o), .clock_busy_o(clock_busy_o));

/* File: test/scsp_host_model.sv */
/* Host serial model at 9600 baud: sends frames, collects device bytes.
   Assumes a 125 MHz clock and 8 bit, no parity frames from the device. */
`timescale 1ns/10ps
module scsp_host_model (
  // Clock
  input wire logic clk_i,
  // Serial lines
  input wire logic dev_tx_i,
  output logic line_o
);
  localparam int BIT = 13008;
  logic [7:0] got_q[$];
  logic [7:0] b;
  int bad_stop;
  task automatic put(input logic v);
    line_o <= v;
    repeat (BIT) @(posedge clk_i);
  endtask
  // Start, data LSB first, optional parity, one stop
  task automatic send(input logic [7:0] d, input int nb, input int hp, input logic pb, input logic st);
    @(posedge clk_i);
    put(1'b0);
    for (int i = 0; i < nb; i++) put(d[i]);
    if (hp != 0) put(pb);
    put(st);
    line_o <= 1'b1;
  endtask
  initial begin
    line_o = 1'b1;
    bad_stop = 0;
    forever begin
      @(negedge dev_tx_i);
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk_i);
        b[i] = dev_tx_i;
      end
      repeat (BIT) @(posedge clk_i);
      if (dev_tx_i !== 1'b1) bad_stop++;
      got_q.push_back(b);
    end
  end
endmodule

/* File: test/test_switch_configured_serial_port.sv */
/* Testbench for the serial port at 9600 baud against a host model.
   Assumes scsp_params.svh and scsp_host_model. */
`timescale 1ns/10ps
`include "scsp_params.svh"
`define CHK(g,e) begin check_count++; if ((g)!==(e)) begin err_total++; $display("mismatch %0t %h/%h",$time,g,e); end end
module test_switch_configured_serial_port;
  localparam int BIT = 13008;
  logic clk_i, rst_i, xon_xoff_sw_i, key_tx_sw_i, line_standard_jumper_i, operating_i, print_key_i;
  logic rx_room_i, read_clock_i, txd_o, loop_transmit_positive_o, rts_o, loop_ready_o, dtr_o;
  logic parity_err_o, key_taken_o, clock_busy_o, host_line;
  logic [2:0] baud_sw_i, fmt_sw_i;
  logic [87:0] rtc_chars_i;
  logic [7:0] key_data_i, last_rx, hb;
  scsp_pkg::scsp_byte_t rx_o;
  wire logic rxd_i = line_standard_jumper_i ? 1'b1 : host_line;
  wire logic loop_receive_i = line_standard_jumper_i ? host_line : 1'b1;
  wire logic host_rx = line_standard_jumper_i ? loop_transmit_positive_o : txd_o;
  int err_total, check_count, rx_cnt, perr_cnt, key_cnt;
  scsp_top scsp_top_i (.clk_i, .rst_i, .baud_sw_i, .fmt_sw_i, .xon_xoff_sw_i, .key_tx_sw_i,
    .line_standard_jumper_i, .rxd_i, .loop_receive_i, .txd_o, .loop_transmit_positive_o, .rts_o,
    .loop_ready_o, .dtr_o, .operating_i, .print_key_i, .rx_room_i, .read_clock_i, .rtc_chars_i,
    .key_data_i, .rx_o, .parity_err_o, .key_taken_o, .clock_busy_o);
  scsp_host_model scsp_host_model_i (.clk_i, .dev_tx_i(host_rx), .line_o(host_line));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(negedge clk_i) begin
    if (rx_o.valid === 1'b1) begin
      rx_cnt++;
      last_rx = rx_o.data;
    end
    if (parity_err_o === 1'b1) perr_cnt++;
    if (key_taken_o === 1'b1) key_cnt++;
  end
  task automatic conclude();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rx_case(input logic [2:0] f, input logic [7:0] d, input int nb, hp, input logic pb, st,
      input int ev, input logic [7:0] ed, input int ep);
    fmt_sw_i <= f;
    repeat (4) @(posedge clk_i);
    rx_cnt = 0;
    perr_cnt = 0;
    scsp_host_model_i.send(d, nb, hp, pb, st);
    repeat (16) @(posedge clk_i);
    `CHK(rx_cnt, ev)
    if (ev != 0) `CHK(last_rx, ed)
    `CHK(perr_cnt, ep)
  endtask
  task automatic wait_host(input logic [7:0] e);
    int i;
    for (i = 0; i < 12 * BIT && scsp_host_model_i.got_q.size() == 0; i++) @(posedge clk_i);
    if (i == 12 * BIT) begin
      err_total++;
      conclude();
    end else begin
      hb = scsp_host_model_i.got_q.pop_front();
      `CHK(hb, e)
    end
  endtask
  initial begin
    rst_i = 1'b1;
    baud_sw_i = `SCSP_BAUD_9600;
    fmt_sw_i = `SCSP_FMT_N81;
    {xon_xoff_sw_i, key_tx_sw_i, line_standard_jumper_i, print_key_i, read_clock_i} = 5'h00;
    {operating_i, rx_room_i} = 2'h3;
    rtc_chars_i = 88'h3132_3435_3139_3031_3933_41;
    key_data_i = 8'h5A;
    {err_total, check_count, key_cnt} = 0;
    repeat (16) @(posedge clk_i);
    `CHK(dtr_o, 1'b0)
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    `CHK(dtr_o, 1'b1)
    `CHK(rts_o, 1'b1)
    rx_room_i <= 1'b0;
    operating_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    `CHK(rts_o, 1'b0)
    `CHK(dtr_o, 1'b0)
    rx_room_i <= 1'b1;
    operating_i <= 1'b1;
    rx_case(`SCSP_FMT_N81, 8'hA5, 8, 0, 1'b0, 1'b1, 1, 8'hA5, 0);
    rx_case(`SCSP_FMT_E81, 8'h3C, 8, 1, 1'b0, 1'b1, 1, 8'h3C, 0);
    rx_case(`SCSP_FMT_E81, 8'h3C, 8, 1, 1'b1, 1'b1, 0, 8'h00, 1);
    rx_case(`SCSP_FMT_O81, 8'h3C, 8, 1, 1'b1, 1'b1, 1, 8'h3C, 0);
    rx_case(`SCSP_FMT_N71, 8'hC1, 7, 0, 1'b0, 1'b1, 1, 8'h41, 0);
    rx_case(`SCSP_FMT_N81, 8'h77, 8, 0, 1'b0, 1'b0, 0, 8'h00, 0);
    line_standard_jumper_i <= 1'b1;
    key_tx_sw_i <= 1'b1;
    rx_room_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    `CHK(loop_ready_o, 1'b0)
    rx_room_i <= 1'b1;
    key_cnt = 0;
    print_key_i <= 1'b1;
    for (int i = 0; i < 2000 && key_cnt == 0; i++) @(posedge clk_i);
    `CHK(key_cnt, 1)
    print_key_i <= 1'b0;
    `CHK(loop_ready_o, 1'b1)
    wait_host(8'h5A);
    key_tx_sw_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    key_cnt = 0;
    print_key_i <= 1'b1;
    repeat (3000) @(posedge clk_i);
    `CHK(key_cnt, 0)
    print_key_i <= 1'b0;
    line_standard_jumper_i <= 1'b0;
    xon_xoff_sw_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rx_room_i <= 1'b0;
    wait_host(`SCSP_XOFF);
    rx_room_i <= 1'b1;
    wait_host(`SCSP_XON);
    `CHK(scsp_host_model_i.bad_stop, 0)
    xon_xoff_sw_i <= 1'b0;
    repeat (BIT) @(posedge clk_i);
    read_clock_i <= 1'b1;
    @(posedge clk_i);
    read_clock_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK(clock_busy_o, 1'b1)
    wait_host(8'h31);
    wait_host(8'h32);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK(clock_busy_o, 1'b0)
    `CHK(txd_o, 1'b1)
    conclude();
  end
endmodule
